// ---- logic/phy_mgmt_pkg.sv ----
// Shared constants and types of the management and mode-control block.
package phy_mgmt_pkg;
  // Register addresses on the management bus.
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_HI = 5'h02;
  localparam logic [4:0] REG_ID_LO = 5'h03;
  localparam logic [4:0] REG_EXT_CTL = 5'h18;
  localparam logic [4:0] REG_INT_CTL_STAT = 5'h1B;
  localparam logic [4:0] REG_CTL1 = 5'h1C;
  localparam logic [4:0] REG_CTL2 = 5'h1F;
  // Field positions.
  localparam int CTL0_LOOPBACK = 14;
  localparam int STATUS_LINK = 2;
  localparam int EXT_B2B10 = 6;
  localparam int INT_EN_MSB = 15;
  localparam int INT_EN_LSB = 8;
  localparam int CTL1_LOCAL_LB = 5;
  localparam int CTL2_SWAP = 14;
  localparam int CTL2_AUTOX = 13;
  localparam int CTL2_IRQ_POL = 9;
  localparam int CTL2_LAMP_HI = 5;
  localparam int CTL2_LAMP_LO = 4;
  localparam int CTL2_REMOTE_LB = 2;
  localparam int AUTOX_STRAP_BIT = 0;
  // Reset values and fixed contents.
  localparam logic [15:0] CONTROL_RESET = 16'h3100;
  localparam logic [15:0] CONTROL_MASK = 16'h7100;
  localparam logic [15:0] STATUS_BASE = 16'h7809;
  localparam logic [1:0] LAMP_DEFAULT = 2'h0;
  localparam logic [1:0] LAMP_ALT = 2'h1;
  localparam logic [1:0] LAMP_LINK = 2'h2;
  // Frame encodings and counts.
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0B;
  localparam logic [5:0] TURN_LAST = 6'h01;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam logic [2:0] B2B_STRAP = 3'h6;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  // Crossing vector widths.
  localparam int CFG_W = 17;
  localparam int STAT_W = 14;
  // Lamp blink half period.
  localparam int BLINK_HALF_MS = 50;
  localparam int CLK_KHZ = 50000;
  localparam int BLINK_CYCLES_DEF = BLINK_HALF_MS * CLK_KHZ;
  localparam int BLINK_W = 22;

  typedef enum logic [4:0] {
    ST_PREAMBLE = 5'h01,
    ST_START = 5'h02,
    ST_HEADER = 5'h04,
    ST_TURN = 5'h08,
    ST_DATA = 5'h10
  } mgmt_state_e;

  typedef enum logic [4:0] {
    FN_OFF = 5'h01,
    FN_LINK = 5'h02,
    FN_LINK_ACT = 5'h04,
    FN_ACT = 5'h08,
    FN_SPEED = 5'h10
  } lamp_fn_e;
endpackage

// ---- logic/pin_sync.sv ----
// Three-stage synchroniser that passes a vector once two stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // The first stage feeds only the second; a change is passed on once stable.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_o <= '0;
    end else if (en_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/lamp_driver.sv ----
// One status lamp output with selectable function.
`timescale 1ns/1ps
`default_nettype none
module lamp_driver (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire phy_mgmt_pkg::lamp_fn_e fn_i,
  input wire logic link_i,
  input wire logic speed_i,
  input wire logic active_i,
  input wire logic phase_i,
  output logic lamp_o
);
  import phy_mgmt_pkg::*;

  // Blinking only while traffic was seen keeps a quiet link steady.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lamp_o <= 1'b0;
    end else if (en_i) begin
      unique case (fn_i)
        FN_OFF: lamp_o <= 1'b0;
        FN_LINK: lamp_o <= link_i;
        FN_LINK_ACT: lamp_o <= link_i & (active_i ? phase_i : 1'b1);
        FN_ACT: lamp_o <= active_i & phase_i;
        FN_SPEED: lamp_o <= link_i & speed_i;
        default: lamp_o <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- logic/phy_mgmt_mode_control.sv ----
// Management serial slave, mode control and status outputs of a 10/100 transceiver.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Collision out when half duplex, both active, in the full-MII package only.
// - Strap 110 selects back-to-back repeater mode.
// - Sixteen-bit registers, 0-8 standard, rest extended.
// - Answer own address; accept broadcast writes.
// - Own address comes from straps at reset.
// - Frame: 32 ones, 01, address, register.
// - Read turnaround Z then 0; write 10.
// - Lamp function chosen by 1Fh bits 5:4.
// - Default lamps: link/activity and speed; small package: link only.
// - Lamp shows link, activity, or speed.
// - Interrupt only for enabled conditions.
// - Status bits record events, clear on read.
// - Interrupt polarity from 1Fh bit 9.
// - Crossover enable from strap, then 1Fh[13].
// - Manual mode: 1Fh bit 14 swaps pairs.
// - Auto mode: follow partner's transmit pair.
// - Local loopback wraps MAC frames back.
// - Remote loopback wraps line frames, 100 full.
module phy_mgmt_mode_control #(
  parameter bit PACKAGE_FULL_MII = 1'b1,
  parameter logic [15:0] ID_HIGH = 16'h0A5A, // Arbitrary identity value.
  parameter logic [15:0] ID_LOW = 16'h5A50, // Arbitrary identity value.
  parameter int BLINK_CYCLES = phy_mgmt_pkg::BLINK_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [2:0] device_address_strap_i,
  input wire logic [2:0] config_strap_i,
  input wire logic link_up_i,
  input wire logic link_speed_100_i,
  input wire logic link_full_duplex_i,
  input wire logic line_tx_active_i,
  input wire logic line_rx_active_i,
  input wire logic partner_on_transmit_pair_i,
  input wire logic partner_on_receive_pair_i,
  input wire logic [5:0] ext_events_i,
  input wire logic mii_tx_en_i,
  input wire logic [3:0] mii_txd_i,
  input wire logic line_rx_dv_i,
  input wire logic [3:0] line_rxd_i,
  output logic mii_rx_dv_o,
  output logic [3:0] mii_rxd_o,
  output logic line_tx_en_o,
  output logic [3:0] line_txd_o,
  output logic col_o,
  output logic status_lamp_first_o,
  output logic status_lamp_second_o,
  output logic irq_output_o,
  output logic pair_crossed_o,
  output logic b2b_mode_o
);
  import phy_mgmt_pkg::*;

  // Management clock domain.
  mgmt_state_e state_reg;
  logic [5:0] cnt_reg;
  logic [15:0] shift_reg;
  logic [15:0] rd_shift_reg;
  logic [15:0] rd_mux;
  logic rd_reg;
  logic wr_reg;
  logic [4:0] regad_reg;
  logic clr_tog_reg;
  logic [15:0] ctl0_reg;
  logic b2b10_reg;
  logic [7:0] int_en_reg;
  logic lb_ctl_reg;
  logic swap_reg;
  logic autox_reg;
  logic autox_wr_reg;
  logic irq_pol_reg;
  logic [1:0] lamp_mode_reg;
  logic remote_reg;
  logic [STAT_W-1:0] from_sys;
  logic [7:0] int_stat_m;
  logic link_m;
  logic [2:0] addr_m;
  logic strap_auto_m;
  logic strap_ok_m;
  logic autox_eff_m;
  logic [11:0] hdr;
  logic [15:0] wdata;
  logic hdr_end;
  logic hdr_rd;
  logic hdr_wr;
  logic wr_now;

  // System clock domain.
  logic [CFG_W-1:0] cfg_s;
  logic [5:0] strap_s;
  logic [2:0] strap_wait_reg;
  logic strap_done_reg;
  logic [2:0] strap_addr_reg;
  logic strap_auto_reg;
  logic [7:0] int_status_reg;
  logic [7:0] int_set;
  logic link_d_reg;
  logic clr_d_reg;
  logic clr_pulse;
  logic lb_s;
  logic lb1c_s;
  logic swap_s;
  logic autox_s;
  logic irq_pol_s;
  logic [1:0] lamp_mode_s;
  logic remote_s;
  logic [7:0] int_en_s;
  logic clr_tog_s;
  logic local_lb;
  logic remote_eff;
  logic [BLINK_W-1:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic act_seen_reg;
  logic act_hold_reg;
  logic period_end;
  lamp_fn_e fn_first;
  lamp_fn_e fn_second;

  // Frame fields are taken whole once the last header bit arrives.
  assign hdr = {shift_reg[10:0], mdio_i};
  assign wdata = {shift_reg[14:0], mdio_i};
  assign {int_stat_m, link_m, addr_m, strap_auto_m, strap_ok_m} = from_sys;
  assign autox_eff_m = autox_wr_reg ? autox_reg : strap_auto_m;
  assign hdr_end = (state_reg == ST_HEADER) && (cnt_reg == HDR_LAST);
  assign hdr_rd = hdr_end && (hdr[11:10] == OP_READ) && strap_ok_m
    && (hdr[9:5] == {2'b00, addr_m});
  assign hdr_wr = hdr_end && (hdr[11:10] == OP_WRITE) && strap_ok_m
    && (hdr[9:8] == 2'b00) && (hdr[7:5] == addr_m || hdr[7:5] == 3'h0);
  assign wr_now = (state_reg == ST_DATA) && (cnt_reg == DATA_LAST) && wr_reg;

  // Frame sequencer; the clock may stop between frames, so nothing waits for it.
  always_ff @(posedge mdc_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_PREAMBLE;
      cnt_reg <= 6'h00;
      shift_reg <= 16'h0000;
    end else begin
      shift_reg <= wdata;
      unique case (state_reg)
        ST_PREAMBLE: begin
          if (mdio_i) begin
            if (cnt_reg != PREAMBLE_ONES) begin
              cnt_reg <= cnt_reg + 6'h01;
            end
          end else begin
            if (cnt_reg == PREAMBLE_ONES) begin
              state_reg <= ST_START;
            end
            cnt_reg <= 6'h00;
          end
        end
        ST_START: begin
          state_reg <= mdio_i ? ST_HEADER : ST_PREAMBLE;
        end
        ST_HEADER: begin
          if (cnt_reg == HDR_LAST) begin
            state_reg <= ST_TURN;
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        ST_TURN: begin
          if (cnt_reg == TURN_LAST) begin
            state_reg <= ST_DATA;
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        ST_DATA: begin
          if (cnt_reg == DATA_LAST) begin
            state_reg <= ST_PREAMBLE;
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= ST_PREAMBLE;
          cnt_reg <= 6'h00;
        end
      endcase
    end
  end

  // Read answer: release during the first turnaround bit, drive 0, then data MSB first.
  always_ff @(posedge mdc_i or posedge rst_i) begin
    if (rst_i) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      regad_reg <= 5'h00;
      rd_shift_reg <= 16'h0000;
      clr_tog_reg <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (hdr_end) begin
      rd_reg <= hdr_rd;
      wr_reg <= hdr_wr;
      regad_reg <= hdr[4:0];
      rd_shift_reg <= rd_mux;
      if (hdr_rd && hdr[4:0] == REG_INT_CTL_STAT) begin
        clr_tog_reg <= ~clr_tog_reg;
      end
    end else if (state_reg == ST_TURN && rd_reg) begin
      mdio_oe_o <= 1'b1;
      if (cnt_reg == TURN_LAST) begin
        mdio_o <= rd_shift_reg[15];
        rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
      end else begin
        mdio_o <= 1'b0;
      end
    end else if (state_reg == ST_DATA && rd_reg) begin
      if (cnt_reg == DATA_LAST) begin
        mdio_oe_o <= 1'b0;
        mdio_o <= 1'b0;
      end else begin
        mdio_o <= rd_shift_reg[15];
        rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
      end
    end
  end

  // Register writes land on the edge that samples the last data bit.
  always_ff @(posedge mdc_i or posedge rst_i) begin
    if (rst_i) begin
      ctl0_reg <= CONTROL_RESET;
      b2b10_reg <= 1'b0;
      int_en_reg <= 8'h00;
      lb_ctl_reg <= 1'b0;
      swap_reg <= 1'b0;
      autox_reg <= 1'b0;
      autox_wr_reg <= 1'b0;
      irq_pol_reg <= 1'b0;
      lamp_mode_reg <= LAMP_DEFAULT;
      remote_reg <= 1'b0;
    end else if (wr_now) begin
      case (regad_reg)
        REG_CONTROL: ctl0_reg <= wdata & CONTROL_MASK;
        REG_EXT_CTL: b2b10_reg <= wdata[EXT_B2B10];
        REG_INT_CTL_STAT: int_en_reg <= wdata[INT_EN_MSB:INT_EN_LSB];
        REG_CTL1: lb_ctl_reg <= wdata[CTL1_LOCAL_LB];
        REG_CTL2: begin
          swap_reg <= wdata[CTL2_SWAP];
          autox_reg <= wdata[CTL2_AUTOX];
          autox_wr_reg <= 1'b1;
          irq_pol_reg <= wdata[CTL2_IRQ_POL];
          lamp_mode_reg <= wdata[CTL2_LAMP_HI:CTL2_LAMP_LO];
          remote_reg <= wdata[CTL2_REMOTE_LB];
        end
        default: ;
      endcase
    end
  end

  // Read data; unlisted addresses read as zero.
  always_comb begin
    rd_mux = 16'h0000;
    case (hdr[4:0])
      REG_CONTROL: rd_mux = ctl0_reg;
      REG_STATUS: begin
        rd_mux = STATUS_BASE;
        rd_mux[STATUS_LINK] = link_m;
      end
      REG_ID_HI: rd_mux = ID_HIGH;
      REG_ID_LO: rd_mux = ID_LOW;
      REG_EXT_CTL: rd_mux[EXT_B2B10] = b2b10_reg;
      REG_INT_CTL_STAT: rd_mux = {int_en_reg, int_stat_m};
      REG_CTL1: rd_mux[CTL1_LOCAL_LB] = lb_ctl_reg;
      REG_CTL2: begin
        rd_mux[CTL2_SWAP] = swap_reg;
        rd_mux[CTL2_AUTOX] = autox_eff_m;
        rd_mux[CTL2_IRQ_POL] = irq_pol_reg;
        rd_mux[CTL2_LAMP_HI:CTL2_LAMP_LO] = lamp_mode_reg;
        rd_mux[CTL2_REMOTE_LB] = remote_reg;
      end
      default: ;
    endcase
  end

  // Crossings: settings to the system side, state and straps to the management side.
  pin_sync #(.W(CFG_W)) u_cfg_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(clk_en_i),
    .d_i({ctl0_reg[CTL0_LOOPBACK], lb_ctl_reg, swap_reg, autox_eff_m, irq_pol_reg,
      lamp_mode_reg, remote_reg, int_en_reg, clr_tog_reg}),
    .q_o(cfg_s)
  );
  pin_sync #(.W(STAT_W)) u_stat_sync (
    .clk_i(mdc_i),
    .rst_i(rst_i),
    .en_i(1'b1),
    .d_i({int_status_reg, link_d_reg, strap_addr_reg, strap_auto_reg, strap_done_reg}),
    .q_o(from_sys)
  );
  pin_sync #(.W(6)) u_strap_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(clk_en_i),
    .d_i({device_address_strap_i, config_strap_i}),
    .q_o(strap_s)
  );
  assign {lb_s, lb1c_s, swap_s, autox_s, irq_pol_s, lamp_mode_s, remote_s, int_en_s,
    clr_tog_s} = cfg_s;

  // Straps are caught once, after the synchroniser has filled behind the reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      strap_wait_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      strap_addr_reg <= 3'h0;
      strap_auto_reg <= 1'b0;
      b2b_mode_o <= 1'b0;
    end else if (clk_en_i && !strap_done_reg) begin
      if (strap_wait_reg == STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        strap_addr_reg <= strap_s[5:3];
        strap_auto_reg <= strap_s[AUTOX_STRAP_BIT];
        b2b_mode_o <= (strap_s[2:0] == B2B_STRAP);
      end else begin
        strap_wait_reg <= strap_wait_reg + 3'h1;
      end
    end
  end

  // Sticky event status; a new event in the clearing cycle survives.
  assign clr_pulse = clr_tog_s ^ clr_d_reg;
  assign int_set = {ext_events_i[5:1], link_d_reg & ~link_up_i, ext_events_i[0],
    link_up_i & ~link_d_reg};
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link_d_reg <= 1'b0;
      clr_d_reg <= 1'b0;
      int_status_reg <= 8'h00;
      irq_output_o <= 1'b1;
    end else if (clk_en_i) begin
      link_d_reg <= link_up_i;
      clr_d_reg <= clr_tog_s;
      int_status_reg <= (clr_pulse ? 8'h00 : int_status_reg) | int_set;
      if (|(int_status_reg & int_en_s)) begin
        irq_output_o <= irq_pol_s;
      end else begin
        irq_output_o <= ~irq_pol_s;
      end
    end
  end

  // Collision, wire-pair choice and the nibble wrap paths.
  assign local_lb = lb_s & lb1c_s;
  assign remote_eff = remote_s & link_up_i & link_speed_100_i & link_full_duplex_i;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      col_o <= 1'b0;
      pair_crossed_o <= 1'b0;
      mii_rx_dv_o <= 1'b0;
      mii_rxd_o <= 4'h0;
      line_tx_en_o <= 1'b0;
      line_txd_o <= 4'h0;
    end else if (clk_en_i) begin
      col_o <= PACKAGE_FULL_MII & ~link_full_duplex_i
        & line_tx_active_i & line_rx_active_i;
      if (!autox_s) begin
        pair_crossed_o <= swap_s;
      end else if (!link_up_i && partner_on_transmit_pair_i) begin
        pair_crossed_o <= 1'b1;
      end else if (!link_up_i && partner_on_receive_pair_i) begin
        pair_crossed_o <= 1'b0;
      end
      mii_rx_dv_o <= local_lb ? mii_tx_en_i : line_rx_dv_i;
      mii_rxd_o <= local_lb ? mii_txd_i : line_rxd_i;
      line_tx_en_o <= remote_eff ? line_rx_dv_i : (mii_tx_en_i & ~local_lb);
      line_txd_o <= remote_eff ? line_rxd_i : mii_txd_i;
    end
  end

  // Blink timing; traffic seen in one half period makes the next one blink.
  assign period_end = (blink_cnt_reg == BLINK_W'(BLINK_CYCLES - 1));
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
      act_seen_reg <= 1'b0;
      act_hold_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (period_end) begin
        blink_cnt_reg <= '0;
        blink_phase_reg <= ~blink_phase_reg;
        act_hold_reg <= act_seen_reg | mii_tx_en_i | line_rx_dv_i;
        act_seen_reg <= 1'b0;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
        act_seen_reg <= act_seen_reg | mii_tx_en_i | line_rx_dv_i;
      end
    end
  end

  // Lamp function per selection; the small package has one lamp only.
  always_comb begin
    fn_first = PACKAGE_FULL_MII ? FN_LINK_ACT : FN_LINK;
    fn_second = PACKAGE_FULL_MII ? FN_SPEED : FN_OFF;
    if (lamp_mode_s == LAMP_ALT) begin
      fn_first = FN_ACT;
      fn_second = PACKAGE_FULL_MII ? FN_LINK : FN_OFF;
    end else if (lamp_mode_s == LAMP_LINK) begin
      fn_first = FN_LINK;
    end
  end

  lamp_driver u_lamp_first (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(clk_en_i),
    .fn_i(fn_first),
    .link_i(link_up_i),
    .speed_i(link_speed_100_i),
    .active_i(act_hold_reg),
    .phase_i(blink_phase_reg),
    .lamp_o(status_lamp_first_o)
  );
  lamp_driver u_lamp_second (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(clk_en_i),
    .fn_i(fn_second),
    .link_i(link_up_i),
    .speed_i(link_speed_100_i),
    .active_i(act_hold_reg),
    .phase_i(blink_phase_reg),
    .lamp_o(status_lamp_second_o)
  );

  // Checks on the management side.
  sequence s_read_turn;
    (state_reg == ST_TURN) && (cnt_reg == 6'h00) && rd_reg;
  endsequence
  sequence s_read_drive;
    (mdio_oe_o && !mdio_o) ##1 mdio_oe_o[*8] ##1 mdio_oe_o[*8] ##1 !mdio_oe_o;
  endsequence
  a_read_turnaround: assert property (@(posedge mdc_i) disable iff (rst_i)
    s_read_turn |=> s_read_drive) else $error("read turnaround or data drive wrong");
  a_idle_release: assert property (@(posedge mdc_i) disable iff (rst_i)
    (state_reg == ST_PREAMBLE) |-> !mdio_oe_o) else $error("data line driven while idle");
  a_start_after_ones: assert property (@(posedge mdc_i) disable iff (rst_i)
    (state_reg == ST_START) |-> $past(cnt_reg) == PREAMBLE_ONES)
    else $error("start accepted without full preamble");
  a_foreign_silent: assert property (@(posedge mdc_i) disable iff (rst_i)
    (hdr_end && hdr[9:5] != {2'b00, addr_m}) |=> !rd_reg)
    else $error("read answered for a foreign address");

  // Checks on the system side.
  a_col_both_active: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && PACKAGE_FULL_MII && !link_full_duplex_i && line_tx_active_i
      && line_rx_active_i) |=> col_o) else $error("collision not reported");
  a_irq_inactive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && (int_status_reg & int_en_s) == 8'h00) |=> irq_output_o == !$past(irq_pol_s))
    else $error("interrupt active without enabled cause");
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && (int_status_reg & int_en_s) != 8'h00) |=> irq_output_o == $past(irq_pol_s))
    else $error("interrupt level does not follow polarity");
  a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !clr_pulse) |=> ($past(int_status_reg) & ~int_status_reg) == 8'h00)
    else $error("status bit lost without a read");
  a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && clr_pulse && link_up_i && !link_d_reg) |=> int_status_reg[0])
    else $error("event lost in clearing cycle");
  a_local_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && local_lb) |=> (mii_rx_dv_o == $past(mii_tx_en_i))
      && (mii_rxd_o == $past(mii_txd_i))) else $error("local wrap data wrong");
  a_remote_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && remote_eff) |=> (line_tx_en_o == $past(line_rx_dv_i))
      && (line_txd_o == $past(line_rxd_i))) else $error("remote wrap data wrong");
  a_manual_pairs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !autox_s) |=> pair_crossed_o == $past(swap_s))
    else $error("manual pair choice not applied");
endmodule
`default_nettype wire

// ---- tb/mgmt_master.sv ----
// Management controller model that frames reads and writes on the serial bus.
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
  input wire logic line_i,
  output logic mdc_o,
  output logic oe_o,
  output logic d_o
);
  // The clock idles low between frames, as a real controller may stop it.
  initial begin
    mdc_o = 1'b0;
    oe_o = 1'b0;
    d_o = 1'b1;
  end
  // Data changes only while the clock is low, so each bit holds across its sampling edge.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++) begin
      oe_o = !(op == 2'h2 && i > 45);
      d_o = f[63-i];
      if (i > 47) rd[63-i] = line_i;
      #15 mdc_o = 1'b1;
      #15 mdc_o = 1'b0;
    end
    // Releasing half a bit late keeps a following frame from touching the line in one step.
    #15 oe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench: register access, interrupt, lamps, collision and local loopback.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import phy_mgmt_pkg::*;
  logic clk_sys_i, rst_i, link_up, spd, fdx, tx_act, rx_act, tx_en, rx_dv, ce;
  logic [3:0] txd, rxd;
  logic [2:0] cfg;
  logic [5:0] ev;
  logic [15:0] rd;
  logic [4:0] bad [3] = '{5'h02, 5'h00, 5'h0D};
  wire logic mdc, m_oe, m_d, mdio_o, mdio_oe, mii_rx_dv, line_tx_en, col, lamp1, lamp2, irq;
  wire logic [3:0] mii_rxd, line_txd;
  wire logic pair_x, b2b;
  // The data line has a pull-up, so a released bus reads high.
  wire logic line = mdio_oe ? mdio_o : (m_oe ? m_d : 1'b1);
  int n_mismatch, checks_done, seed, cyc;
  int exp_map[int];
  logic [4:0] nib_q[$];
  mgmt_master mgmt_u (.line_i(line), .mdc_o(mdc), .oe_o(m_oe), .d_o(m_d));
  phy_mgmt_mode_control #(.BLINK_CYCLES(8)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .clk_en_i(ce), .mdc_i(mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe),
    .device_address_strap_i(3'h5), .config_strap_i(cfg), .link_up_i(link_up),
    .link_speed_100_i(spd), .link_full_duplex_i(fdx), .line_tx_active_i(tx_act),
    .line_rx_active_i(rx_act), .partner_on_transmit_pair_i(1'b0),
    .partner_on_receive_pair_i(1'b0), .ext_events_i(ev), .mii_tx_en_i(tx_en),
    .mii_txd_i(txd), .line_rx_dv_i(rx_dv), .line_rxd_i(rxd), .mii_rx_dv_o(mii_rx_dv),
    .mii_rxd_o(mii_rxd), .line_tx_en_o(line_tx_en), .line_txd_o(line_txd), .col_o(col),
    .status_lamp_first_o(lamp1), .status_lamp_second_o(lamp2), .irq_output_o(irq),
    .pair_crossed_o(pair_x), .b2b_mode_o(b2b));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // A hung handshake is cut off well past the roughly 1500 cycles the run needs.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic mw(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    mgmt_u.xfer(OP_WRITE, pa, ra, d, rd);
    exp_map[ra] = d;
  endtask
  task automatic mr(input logic [4:0] pa, input logic [4:0] ra);
    mgmt_u.xfer(OP_READ, pa, ra, 16'h0000, rd);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  initial begin
    {seed, n_mismatch, checks_done, cyc} = {32'd45, 96'd0};
    {rst_i, link_up, spd, fdx, tx_act, rx_act, tx_en, rx_dv, txd, rxd, ev} = 22'h240000;
    {ce, cfg} = 4'h8;
    ticks(8);
    rst_i = 1'b0;
    check(16'(irq), 16'h1);
    ticks(20);
    check(16'(b2b), 16'h0);
    // Broadcast write, own read back, refused reads leave the line to the pull-up.
    mw(5'h00, REG_INT_CTL_STAT, 16'hFF00);
    mr(5'h05, REG_INT_CTL_STAT);
    check(rd, 16'(exp_map[REG_INT_CTL_STAT]));
    foreach (bad[i]) begin
      mr(bad[i], REG_INT_CTL_STAT);
      check(rd, 16'hFFFF);
    end
    $display("register test done");
    // Link up is an enabled event; the read reports it once and clears it.
    link_up = 1'b1;
    ticks(4);
    check(16'(irq), 16'h0);
    mr(5'h05, REG_INT_CTL_STAT);
    check(rd, 16'hFF01);
    ticks(10);
    check(16'(irq), 16'h1);
    mr(5'h05, REG_INT_CTL_STAT);
    check(rd, 16'hFF00);
    mw(5'h05, REG_CTL2, 16'h0200);
    ticks(6);
    check(16'(irq), 16'h0);
    for (int s = 0; s < 2; s++) begin
      spd = s[0];
      ticks(3);
      check(16'(lamp2), 16'(s[0]));
      check(16'(lamp1), 16'h1);
    end
    $display("interrupt and lamp test done");
    // Half duplex with random activity; other events toggle meanwhile.
    fdx = 1'b0;
    repeat (40) begin
      ticks(1);
      {ev, tx_act, rx_act} = 8'($random(seed));
      ticks(1);
      check(16'(col), 16'(tx_act & rx_act));
    end
    // A low clock enable must hold the collision flag until it returns.
    {tx_act, rx_act} = 2'h0;
    ticks(1);
    {tx_act, rx_act, ce} = 3'h6;
    ticks(2);
    check(16'(col), 16'h0);
    ce = 1'b1;
    ticks(1);
    check(16'(col), 16'h1);
    {fdx, tx_act, rx_act} = 3'h4;
    $display("collision test done");
    mw(5'h05, REG_CONTROL, 16'h4100);
    mw(5'h05, REG_CTL1, 16'h0020);
    ticks(6);
    repeat (40) begin
      {tx_en, txd} = 5'($random(seed));
      nib_q.push_back({tx_en, txd});
      ticks(1);
      check(16'({mii_rx_dv, mii_rxd}), 16'(nib_q.pop_front()));
      check(16'(line_tx_en), 16'h0);
    end
    $display("loopback test done");
    // Remote wrap at 100 Mbps full duplex, with the pairs crossed by hand meanwhile.
    {spd, fdx} = 2'h3;
    mw(5'h05, REG_CTL2, 16'h4204);
    ticks(6);
    check(16'(pair_x), 16'h1);
    repeat (20) begin
      {rx_dv, rxd} = 5'($random(seed));
      ticks(1);
      check(16'({line_tx_en, line_txd}), 16'({rx_dv, rxd}));
    end
    $display("remote loopback test done");
    // Reset again with the back-to-back strap; the controller then sets the 10 Mbps bit.
    {rst_i, cfg} = 4'hE;
    ticks(2);
    rst_i = 1'b0;
    ticks(8);
    check(16'(b2b), 16'h1);
    mw(5'h05, REG_EXT_CTL, 16'h0040);
    mr(5'h05, REG_EXT_CTL);
    check(rd, 16'h0040);
    repeat (8) begin
      {tx_en, txd} = 5'($random(seed));
      ticks(1);
      check(16'({line_tx_en, line_txd}), 16'({tx_en, txd}));
    end
    $display("back-to-back test done");
    give_verdict();
  end
endmodule
`default_nettype wire
